/* File: design/boundary_scan_tap_port.v */
`timescale 1ns/1ns
`include "tap_port_regs.vh"
module boundary_scan_tap_port
#(
   parameter [31:0] ID_CODE = 32'h00000001 // arbitrary value
)
(
   input wire clk,
   input wire reset_n,
   input wire test_port_reset_n,
   input wire test_port_clock,
   input wire test_port_mode_select,
   input wire test_port_serial_in,
   output reg test_port_serial_out,
   output reg test_port_serial_out_en,
   output wire [3:0] tapState,
   output wire [3:0] instruction
);
   wire [3:0] syncPins;
   wire tckS;
   wire tmsS;
   wire tdiS;
   wire trstS;
   reg tckPrev_ff;
   reg [3:0] state_ff;
   reg [3:0] nxt_state;
   reg [3:0] irShift_ff;
   reg [3:0] ir_ff;
   reg [31:0] idShift_ff;
   reg bypass_ff;
   reg tdoBit;
   reg nxt_serialOut;
   reg [1:0] settle_ff;
   wire rise;
   wire fall;
   wire tapReset;
   wire stepEn;
   wire dropEn;
   wire capDr;
   wire shiftDr;
   wire capIr;
   wire shiftIr;
   wire updIr;
   wire toReset;

   // the test reset is also sampled; a 4 ns clock sees any assertion in two cycles
   tap_pin_sync u_sync
   (
      .clk(clk),
      .reset_n(reset_n),
      .pinIn({test_port_reset_n, test_port_clock, test_port_mode_select,
         test_port_serial_in}),
      .pinOut(syncPins)
   );
   assign trstS = syncPins[3];
   assign tckS = syncPins[2];
   assign tmsS = syncPins[1];
   assign tdiS = syncPins[0];
   // a 10MHz test clock gives 25 samples per period, so no edge is missed
   assign rise = tckS & ~tckPrev_ff;
   assign fall = ~tckS & tckPrev_ff;
   assign tapState = state_ff;
   assign instruction = ir_ff;

   function isShift;
      input [3:0] s;
      begin
         isShift = (s == `TAP_SHIFT_DR) || (s == `TAP_SHIFT_IR);
      end
   endfunction

   always @*
   begin
      case (state_ff)
         `TAP_RESET: nxt_state = tmsS ? `TAP_RESET : `TAP_IDLE;
         `TAP_IDLE: nxt_state = tmsS ? `TAP_SEL_DR : `TAP_IDLE;
         `TAP_SEL_DR: nxt_state = tmsS ? `TAP_SEL_IR : `TAP_CAP_DR;
         `TAP_CAP_DR: nxt_state = tmsS ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
         `TAP_SHIFT_DR: nxt_state = tmsS ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
         `TAP_EXIT1_DR: nxt_state = tmsS ? `TAP_UPD_DR : `TAP_PAUSE_DR;
         `TAP_PAUSE_DR: nxt_state = tmsS ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
         `TAP_EXIT2_DR: nxt_state = tmsS ? `TAP_UPD_DR : `TAP_SHIFT_DR;
         `TAP_UPD_DR: nxt_state = tmsS ? `TAP_SEL_DR : `TAP_IDLE;
         `TAP_SEL_IR: nxt_state = tmsS ? `TAP_RESET : `TAP_CAP_IR;
         `TAP_CAP_IR: nxt_state = tmsS ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
         `TAP_SHIFT_IR: nxt_state = tmsS ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
         `TAP_EXIT1_IR: nxt_state = tmsS ? `TAP_UPD_IR : `TAP_PAUSE_IR;
         `TAP_PAUSE_IR: nxt_state = tmsS ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
         `TAP_EXIT2_IR: nxt_state = tmsS ? `TAP_UPD_IR : `TAP_SHIFT_IR;
         `TAP_UPD_IR: nxt_state = tmsS ? `TAP_SEL_DR : `TAP_IDLE;
         default: nxt_state = `TAP_RESET;
      endcase
   end

   always @*
   begin
      if (state_ff == `TAP_SHIFT_IR)
         tdoBit = irShift_ff[0];
      else if (ir_ff == `IR_IDCODE)
         tdoBit = idShift_ff[0];
      else
         tdoBit = bypass_ff;
   end

   always @*
   begin
      if (isShift(state_ff))
         nxt_serialOut = tdoBit;
      else
         nxt_serialOut = 1'h0;
   end

   // the first edges after system reset only fill the pin synchroniser; a clock pin
   // idling high would otherwise look like a test-clock rise
   always @(posedge clk)
   begin
      if (!reset_n)
         settle_ff <= `SYNC_SETTLE;
      else if (settle_ff != 2'h0)
         settle_ff <= settle_ff - 2'h1;
      else
         settle_ff <= settle_ff;
   end

   always @(posedge clk)
   begin
      tckPrev_ff <= tckS;
   end

   // test reset does not wait for a test-clock edge: it acts on the third system clock after the pin falls
   assign tapReset = !reset_n || !trstS || (settle_ff != 2'h0);
   assign stepEn = rise && !tapReset;
   assign dropEn = fall && !tapReset;
   assign capDr = stepEn && (state_ff == `TAP_CAP_DR);
   assign shiftDr = stepEn && (state_ff == `TAP_SHIFT_DR);
   assign capIr = stepEn && (state_ff == `TAP_CAP_IR);
   assign shiftIr = stepEn && (state_ff == `TAP_SHIFT_IR);
   assign updIr = stepEn && (state_ff == `TAP_UPD_IR);
   assign toReset = stepEn && ((state_ff == `TAP_RESET) || (nxt_state == `TAP_RESET));

   always @(posedge clk)
   begin
      if (tapReset)
         state_ff <= `TAP_RESET;
      else if (stepEn)
         state_ff <= nxt_state;
      else
         state_ff <= state_ff;
   end

   // capture loads a fixed pattern whose low bits let the far side find the chain length
   always @(posedge clk)
   begin
      if (tapReset)
         irShift_ff <= `IR_CAPTURE;
      else if (capIr)
         irShift_ff <= `IR_CAPTURE;
      else if (shiftIr)
         irShift_ff <= {tdiS, irShift_ff[3:1]};
      else
         irShift_ff <= irShift_ff;
   end

   // the new instruction takes effect only as update is left, never mid-shift
   always @(posedge clk)
   begin
      if (tapReset)
         ir_ff <= `IR_IDCODE;
      else if (updIr)
         ir_ff <= irShift_ff;
      else if (toReset)
         ir_ff <= `IR_IDCODE;
      else
         ir_ff <= ir_ff;
   end

   always @(posedge clk)
   begin
      if (tapReset)
         idShift_ff <= `ID_SHIFT_RESET;
      else if (capDr)
         idShift_ff <= ID_CODE;
      else if (shiftDr)
         idShift_ff <= {tdiS, idShift_ff[31:1]};
      else
         idShift_ff <= idShift_ff;
   end

   // bypass is a single flop, so a stream passes with one test-clock delay
   always @(posedge clk)
   begin
      if (tapReset)
         bypass_ff <= `BYPASS_RESET;
      else if (capDr)
         bypass_ff <= 1'h0;
      else if (shiftDr)
         bypass_ff <= tdiS;
      else
         bypass_ff <= bypass_ff;
   end

   // outside reset, out and enable move only on a test-clock fall, half a period before the far side
   // samples them
   always @(posedge clk)
   begin
      if (tapReset)
      begin
         test_port_serial_out <= `SERIAL_OUT_RESET;
         test_port_serial_out_en <= 1'h0;
      end
      else if (dropEn)
      begin
         test_port_serial_out <= nxt_serialOut;
         test_port_serial_out_en <= isShift(state_ff);
      end
      else
      begin
         test_port_serial_out <= test_port_serial_out;
         test_port_serial_out_en <= test_port_serial_out_en;
      end
   end
endmodule

/* File: design/tap_port_regs.vh */
`ifndef TAP_PORT_REGS_VH
`define TAP_PORT_REGS_VH
`define TAP_RESET 4'h0
`define TAP_IDLE 4'h1
`define TAP_SEL_DR 4'h2
`define TAP_CAP_DR 4'h3
`define TAP_SHIFT_DR 4'h4
`define TAP_EXIT1_DR 4'h5
`define TAP_PAUSE_DR 4'h6
`define TAP_EXIT2_DR 4'h7
`define TAP_UPD_DR 4'h8
`define TAP_SEL_IR 4'h9
`define TAP_CAP_IR 4'ha
`define TAP_SHIFT_IR 4'hb
`define TAP_EXIT1_IR 4'hc
`define TAP_PAUSE_IR 4'hd
`define TAP_EXIT2_IR 4'he
`define TAP_UPD_IR 4'hf
`define IR_WIDTH 4
`define IR_BYPASS 4'hf
`define IR_IDCODE 4'h1
`define IR_CAPTURE 4'h1
`define ID_WIDTH 32
`define TEST_CLOCK_MAX_MHZ 10
`define SYS_CLOCK_MHZ 250
`define TEST_CLOCK_MIN_CYCLES (`SYS_CLOCK_MHZ / `TEST_CLOCK_MAX_MHZ)
`define SYNC_SETTLE 2'h3
`define ID_SHIFT_RESET 32'h00000000
`define BYPASS_RESET 1'h0
`define SERIAL_OUT_RESET 1'h0
`endif

/* File: design/tap_pin_sync.v */
`timescale 1ns/1ns
module tap_pin_sync
(
   clk,
   reset_n,
   pinIn,
   pinOut
);
   input wire clk;
   input wire reset_n;
   input wire [3:0] pinIn;
   output wire [3:0] pinOut;
   reg [3:0] stage1_ff;
   reg [3:0] stage2_ff;
   genvar i;
   generate
      for (i = 0; i < 4; i = i + 1)
      begin : g_bit
         always @(posedge clk)
         begin
            if (!reset_n)
            begin
               stage1_ff[i] <= 1'b0;
               stage2_ff[i] <= 1'b0;
            end
            else
            begin
               stage1_ff[i] <= pinIn[i];
               stage2_ff[i] <= stage1_ff[i];
            end
         end
      end
   endgenerate
   assign pinOut = stage2_ff;
endmodule

/* File: sim/tap_port_sva.sv */
`timescale 1ns/1ns
module tap_port_sva
(
   input wire clk,
   input wire reset_n,
   input wire test_port_reset_n,
   input wire test_port_clock,
   input wire test_port_serial_out,
   input wire test_port_serial_out_en,
   input wire [3:0] tapState
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n || !test_port_reset_n);
   a_trst_reset: assert property (disable iff (!reset_n)
      !test_port_reset_n [*3] |=> tapState == 4'h0) else $error("test reset ignored");
   a_state_rise: assert property (
      $changed(tapState) |-> $past(test_port_clock, 2)) else $error("state off rise");
   a_out_fall: assert property (
      $changed(test_port_serial_out) |-> !$past(test_port_clock, 2)) else $error("out off fall");
   a_en_shift: assert property (
      $changed(test_port_serial_out_en) |->
      test_port_serial_out_en == (tapState == 4'h4 || tapState == 4'hb)) else $error("bad enable");
   a_cap_next: assert property (
      $changed(tapState) && $past(tapState) == 4'h3 |-> tapState inside {4'h4, 4'h5})
      else $error("bad step after capture");
endmodule
bind boundary_scan_tap_port tap_port_sva chk (.clk(clk), .reset_n(reset_n),
   .test_port_reset_n(test_port_reset_n), .test_port_clock(test_port_clock),
   .test_port_serial_out(test_port_serial_out),
   .test_port_serial_out_en(test_port_serial_out_en), .tapState(tapState));

/* File: sim/tap_controller_model.sv */
`timescale 1ns/1ns
module tap_controller_model
(
   output reg testClock = 1'h0,
   output reg modeSelect = 1'h1,
   output reg serialIn = 1'h1,
   input wire serialOut,
   input wire serialOutEn
);
   // one 125 ns clock period per call; the clock rests low between calls
   task step(input m, input d, output o, output e);
   begin
      modeSelect = m;
      serialIn = d;
      #30 testClock = 1'h1;
      #62 testClock = 1'h0;
      #33 o = serialOut;
      e = serialOutEn;
   end
   endtask
endmodule

/* File: sim/boundary_scan_tap_port_bench.sv */
`timescale 1ns/1ns
module boundary_scan_tap_port_bench;
   localparam [31:0] ID = 32'h9e37c5a1; // arbitrary value
   reg clk, reset_n, trstN, o, e;
   wire tck, tms, tdi, tdo, tdoEn;
   wire [3:0] tapState, instruction;
   integer n_fail = 0, n_tests = 0, i;
   boundary_scan_tap_port #(.ID_CODE(ID)) DUT (.clk(clk), .reset_n(reset_n),
      .test_port_reset_n(trstN), .test_port_clock(tck), .test_port_mode_select(tms),
      .test_port_serial_in(tdi), .test_port_serial_out(tdo),
      .test_port_serial_out_en(tdoEn), .tapState(tapState), .instruction(instruction));
   tap_controller_model ctl (.testClock(tck), .modeSelect(tms), .serialIn(tdi),
      .serialOut(tdo), .serialOutEn(tdoEn));
   task check(input [31:0] seen, input [31:0] want);
   begin
      n_tests = n_tests + 1;
      if (seen !== want)
      begin
         n_fail = n_fail + 1;
         $display("BAD %0t saw %h want %h", $time, seen, want);
      end
   end
   endtask
   task final_report;
   begin
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask
   task id_scan;
   begin
      for (i = 0; i < 8; i = i + 1)
         ctl.step(i == 5, 1'h0, o, e);
      check({e, o}, {1'h1, ID[0]});
      for (i = 1; i < 32; i = i + 1)
      begin
         ctl.step(1'h0, 1'h0, o, e);
         check({e, o}, {1'h1, ID[i]});
      end
      ctl.step(1'h1, 1'h0, o, e);
      check({tapState, e}, {4'h5, 1'h0});
   end
   endtask
   task ir_bypass;
   begin
      for (i = 0; i < 4; i = i + 1)
         ctl.step(i < 3, 1'h0, o, e);
      for (i = 0; i < 5; i = i + 1)
      begin
         ctl.step(i == 4, 1'h1, o, e);
         check({e, o}, {i < 4, i == 0});
      end
      // the instruction lands as update is left
      ctl.step(1'h1, 1'h0, o, e);
      ctl.step(1'h1, 1'h0, o, e);
      check(instruction, 4'hf);
      for (i = 0; i < 3; i = i + 1)
         ctl.step(1'h0, i == 2, o, e);
      check({e, o}, 2'h3);
   end
   endtask
   // no test clock runs while the test reset is low
   task test_reset;
   begin
      @(posedge clk);
      #1 trstN = 1'h0;
      repeat (4) @(posedge clk);
      #1 check({tapState, instruction, tdoEn}, {4'h0, 4'h1, 1'h0});
      trstN = 1'h1;
      ctl.step(1'h0, 1'h0, o, e);
      check(tapState, 4'h1);
   end
   endtask
   initial
   begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      reset_n = 1'h0;
      trstN = 1'h0;
      repeat (4) @(posedge clk);
      #1 reset_n = 1'h1;
      trstN = 1'h1;
      id_scan;
      ir_bypass;
      test_reset;
      final_report;
   end
endmodule
